// [pkg/smp_pkg.sv]
// Shared constants of the servo motion protection block: register map,
// field positions, reset values and mode codes.
// Assumes a 32-bit AXI4-Lite register bus and a 50 MHz system clock.
package smp_pkg;

  // Register byte offsets
  localparam logic [7:0] SMP_OFS_CTRL       = 8'h00;
  localparam logic [7:0] SMP_OFS_TRAVEL     = 8'h04;
  localparam logic [7:0] SMP_OFS_DEV_LEVEL  = 8'h08;
  localparam logic [7:0] SMP_OFS_HYB_LEVEL  = 8'h0C;
  localparam logic [7:0] SMP_OFS_OVS_LEVEL  = 8'h10;
  localparam logic [7:0] SMP_OFS_STATUS     = 8'h14;
  localparam logic [7:0] SMP_OFS_MASK       = 8'h18;
  localparam logic [7:0] SMP_OFS_RANGE_MIN  = 8'h1C;
  localparam logic [7:0] SMP_OFS_RANGE_MAX  = 8'h20;
  localparam logic [7:0] SMP_OFS_ALARMS     = 8'h24;

  // Control register fields
  localparam int SMP_CTRL_MODE_LSB  = 0;  // Two bits: control mode
  localparam int SMP_CTRL_STOP_LSB  = 2;  // Two bits: alarm stop sequence
  localparam int SMP_CTRL_UNIT_BIT  = 4;  // Deviation unit select
  localparam int SMP_CTRL_OTSEQ_LSB = 5;  // Two bits: over-travel sequence
  localparam int SMP_CTRL_ACLR_BIT  = 7;  // Write 1: clear latched alarms

  // Control mode codes
  localparam logic [1:0] SMP_MODE_POSITION = 2'h0;
  localparam logic [1:0] SMP_MODE_VELOCITY = 2'h1;
  localparam logic [1:0] SMP_MODE_TORQUE   = 2'h2;
  localparam logic [1:0] SMP_MODE_FULL_CL  = 2'h3;

  // Over-travel sequence code that clears the deviation
  localparam logic [1:0] SMP_OTSEQ_CLEAR = 2'h2;

  // Event / alarm bit positions
  localparam int SMP_EV_RANGE = 0;
  localparam int SMP_EV_DEV   = 1;
  localparam int SMP_EV_HYB   = 2;
  localparam int SMP_EV_OVS   = 3;
  localparam int SMP_EV_N     = 4;

  // Alarm numbers, reported for software
  localparam logic [7:0] SMP_ALM_RANGE_NO = 8'h22;  // 34
  localparam logic [7:0] SMP_ALM_DEV_NO   = 8'h18;  // 24.0
  localparam logic [7:0] SMP_ALM_HYB_NO   = 8'h19;  // 25.0
  localparam logic [7:0] SMP_ALM_OVS_NO   = 8'h1A;  // 26.0

  // Reset values
  localparam logic [31:0] SMP_RST_CTRL      = 32'h0000_0000;
  localparam logic [31:0] SMP_RST_TRAVEL    = 32'h0000_2710;  // 10000
  localparam logic [31:0] SMP_RST_DEV_LEVEL = 32'h0001_86A0;  // 100000
  localparam logic [31:0] SMP_RST_HYB_LEVEL = 32'h0000_3E80;  // 16000
  localparam logic [31:0] SMP_RST_MASK      = 32'h0000_0000;
  localparam int          SMP_OVS_NUM       = 12;             // Factor 1.2
  localparam int          SMP_OVS_DEN       = 10;

  // AXI responses
  localparam logic [1:0] SMP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SMP_RESP_SLVERR = 2'h2;

  // Alarm stop sequence states
  typedef enum logic [1:0] {SMP_RUN, SMP_DECEL, SMP_HALT} smp_stop_type;

endpackage : smp_pkg

// [hw/smp_range_track.sv]
// Accumulates position command steps and tracks their running min and max.
// Assumes one step per valid cycle and a synchronous clear from the caller.
`timescale 1ns/10ps
`default_nettype none
module smp_range_track #(
  parameter int W = 32
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                clear,
  input  wire logic                step_valid,
  input  wire logic signed [W-1:0] step,
  output logic signed [W-1:0]      acc_q,
  output logic signed [W-1:0]      min_q,
  output logic signed [W-1:0]      max_q
);

  logic signed [W-1:0] acc_d;

  // Next accumulated command position
  always_comb begin
    acc_d = step_valid ? acc_q + step : acc_q;
  end

  // Running extent; clear pulls everything back to the origin
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      acc_q <= '0;
      min_q <= '0;
      max_q <= '0;
    end else begin
      acc_q <= acc_d;
      if (acc_d < min_q) min_q <= acc_d;
      if (acc_d > max_q) max_q <= acc_d;
    end
  end

endmodule : smp_range_track
`default_nettype wire

// [hw/smp_protect.sv]
// Servo motion protection: working range, deviation, hybrid deviation and
// over-speed supervision, with an AXI4-Lite register file and interrupt.
// Assumes all drive-side inputs are synchronous to aclk; servo_on, the clear and test flags are levels.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// How it works
// RL1: Motor beyond command range plus travel raises working-range alarm 34 and stops.
// RL2: Working-range check only in position or full-closed control mode.
// RL3: Working-range check only with servo on; servo off gives no alarm.
// RL4: Alarm stop decelerates by the configured stop sequence, not an abrupt cut.
// RL5: Tool trial run or frequency measurement disables working-range protection.
// RL6: Without commands the range is travel on both sides of motor position.
// RL7: Commands widen range to command input range plus travel each side.
// RL8: Command input range is cleared to zero at power-up.
// RL9: Range held at zero while deviation is cleared, including over-travel sequence 2.
// RL10: Range cleared at start and end of communication trial run.
// RL11: Over-speed alarm 26.0 when speed exceeds level; default max speed times 1.2.
// RL12: Deviation alarm 24.0 in position or full-closed when deviation exceeds level.
// RL13: Unit select 0 uses command-unit deviation, 1 encoder or full-closed deviation.
// RL14: Deviation level defaults to 100000 command-unit pulses.
// RL15: With unit select 1, filter and damping settings do not affect deviation.
// RL16: Full-closed hybrid deviation beyond level raises alarm 25.0; default 16000.
// RL17: Torque-in-limit output follows motor torque held at its limit.
// RL18: Command range is running min and max of accumulated command position.
module smp_protect
  import smp_pkg::*;
#(
  parameter int          POS_W           = 32,
  parameter logic [31:0] MOTOR_MAX_SPEED = 32'h0000_1388  // 5000 r/min
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite slave
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [7:0]              s_axi_araddr,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  // Drive side
  input  wire logic                    servo_on,
  input  wire logic                    cmd_step_valid,
  input  wire logic signed [POS_W-1:0] cmd_step,
  input  wire logic signed [POS_W-1:0] motor_pos,
  input  wire logic signed [POS_W-1:0] scale_pos,
  input  wire logic signed [POS_W-1:0] cmd_unit_deviation,
  input  wire logic signed [POS_W-1:0] enc_unit_deviation,
  input  wire logic signed [POS_W-1:0] motor_speed,
  input  wire logic                    torque_at_limit,
  input  wire logic                    deviation_clear,
  input  wire logic                    overtravel_inhibit,
  input  wire logic                    tool_trial_run,
  input  wire logic                    tool_freq_measure,
  input  wire logic                    comm_trial_run,
  output logic                         torque_in_limit_output,
  output logic                         decel_stop_q,
  output logic                         motor_halted_q,
  output logic [1:0]                   stop_sequence_q,
  output logic [SMP_EV_N-1:0]          alarm_q,
  output logic                         irq_q
);

  // Elaboration check on the datapath width
  if (POS_W < 16 || POS_W > 32) begin : g_bad_width
    $error("smp_protect: POS_W must lie in 16..32");
  end

  localparam int EW = POS_W + 2;  // Headroom for range sums
  localparam logic [31:0] OVS_RST = 32'(MOTOR_MAX_SPEED * SMP_OVS_NUM / SMP_OVS_DEN);

  // Sign-extend into the wide compare domain
  function automatic logic signed [EW-1:0] ext(input logic signed [POS_W-1:0] v);
    ext = EW'(v);
  endfunction : ext

  // Magnitude of a signed value, used by every level compare
  function automatic logic [EW-1:0] mag(input logic signed [EW-1:0] v);
    mag = v[EW-1] ? EW'(-v) : v;
  endfunction : mag

  // Configuration and status registers
  logic [31:0]         ctrl_q;
  logic [31:0]         travel_q;
  logic [31:0]         dev_level_q;
  logic [31:0]         hyb_level_q;
  logic [31:0]         ovs_level_q;
  logic [SMP_EV_N-1:0] status_q;
  logic [SMP_EV_N-1:0] mask_q;

  // Bus bookkeeping
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_take;
  logic        w_take;
  logic        wr_do;
  logic        ar_take;
  logic        wr_hit;
  logic        rd_hit;
  logic        status_rd;

  // Protection datapath
  logic signed [POS_W-1:0] acc_q;
  logic signed [POS_W-1:0] min_q;
  logic signed [POS_W-1:0] max_q;
  logic signed [POS_W-1:0] base_q;
  logic                    comm_trial_q;
  logic                    range_clear;
  logic                    pos_mode;
  logic                    full_mode;
  logic                    range_armed;
  logic signed [EW-1:0]    rel_pos;
  logic signed [EW-1:0]    lo_lim;
  logic signed [EW-1:0]    hi_lim;
  logic [EW-1:0]           dev_mag;
  logic [SMP_EV_N-1:0]     det;
  logic [SMP_EV_N-1:0]     evt;
  logic                    alarm_clr;
  smp_stop_type            stop_q;

  // Register address decode
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      SMP_OFS_CTRL, SMP_OFS_TRAVEL, SMP_OFS_DEV_LEVEL, SMP_OFS_HYB_LEVEL,
      SMP_OFS_OVS_LEVEL, SMP_OFS_STATUS, SMP_OFS_MASK, SMP_OFS_RANGE_MIN,
      SMP_OFS_RANGE_MAX, SMP_OFS_ALARMS: mapped = 1'b1;
      default:                           mapped = 1'b0;
    endcase
  endfunction : mapped

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge

  assign aw_take   = s_axi_awvalid & s_axi_awready;
  assign w_take    = s_axi_wvalid & s_axi_wready;
  assign wr_do     = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign ar_take   = s_axi_arvalid & s_axi_arready;
  assign wr_hit    = mapped(awaddr_q);
  assign rd_hit    = mapped(s_axi_araddr);
  assign status_rd = ar_take & (s_axi_araddr == SMP_OFS_STATUS);
  assign alarm_clr = wr_do & (awaddr_q == SMP_OFS_CTRL) & wstrb_q[0]
                   & wdata_q[SMP_CTRL_ACLR_BIT];

  // Write channels: address and data taken in either order, answered together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= SMP_RESP_OKAY;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else begin
      aw_have_q     <= (aw_have_q | aw_take) & ~wr_do;
      w_have_q      <= (w_have_q | w_take) & ~wr_do;
      s_axi_awready <= ~(aw_have_q | aw_take) & ~(s_axi_bvalid | wr_do);
      s_axi_wready  <= ~(w_have_q | w_take) & ~(s_axi_bvalid | wr_do);
      if (aw_take) awaddr_q <= s_axi_awaddr;
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? SMP_RESP_OKAY : SMP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers; the alarm-clear bit is a strobe and never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q      <= SMP_RST_CTRL;
      travel_q    <= SMP_RST_TRAVEL;
      dev_level_q <= SMP_RST_DEV_LEVEL;  // [RL14]
      hyb_level_q <= SMP_RST_HYB_LEVEL;  // [RL16]
      ovs_level_q <= OVS_RST;            // [RL11]
      mask_q      <= SMP_EV_N'(SMP_RST_MASK);
    end else if (wr_do) begin
      case (awaddr_q)
        SMP_OFS_CTRL: begin
          ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & ~(32'h0000_0001 << SMP_CTRL_ACLR_BIT);
        end
        SMP_OFS_TRAVEL:    travel_q    <= merge(travel_q, wdata_q, wstrb_q);
        SMP_OFS_DEV_LEVEL: dev_level_q <= merge(dev_level_q, wdata_q, wstrb_q);
        SMP_OFS_HYB_LEVEL: hyb_level_q <= merge(hyb_level_q, wdata_q, wstrb_q);
        SMP_OFS_OVS_LEVEL: ovs_level_q <= merge(ovs_level_q, wdata_q, wstrb_q);
        SMP_OFS_MASK:      mask_q      <= wstrb_q[0] ? wdata_q[SMP_EV_N-1:0] : mask_q;
        default: ;
      endcase
    end
  end

  // Read channel; data registered at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= SMP_RESP_OKAY;
    end else begin
      s_axi_arready <= ~(s_axi_rvalid | ar_take);
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_hit ? SMP_RESP_OKAY : SMP_RESP_SLVERR;
        case (s_axi_araddr)
          SMP_OFS_CTRL:      s_axi_rdata <= ctrl_q;
          SMP_OFS_TRAVEL:    s_axi_rdata <= travel_q;
          SMP_OFS_DEV_LEVEL: s_axi_rdata <= dev_level_q;
          SMP_OFS_HYB_LEVEL: s_axi_rdata <= hyb_level_q;
          SMP_OFS_OVS_LEVEL: s_axi_rdata <= ovs_level_q;
          SMP_OFS_STATUS:    s_axi_rdata <= 32'(status_q);
          SMP_OFS_MASK:      s_axi_rdata <= 32'(mask_q);
          SMP_OFS_RANGE_MIN: s_axi_rdata <= 32'(min_q);
          SMP_OFS_RANGE_MAX: s_axi_rdata <= 32'(max_q);
          SMP_OFS_ALARMS:    s_axi_rdata <= 32'(alarm_q);
          default:           s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Mode decode from the control register
  assign full_mode = ctrl_q[SMP_CTRL_MODE_LSB +: 2] == SMP_MODE_FULL_CL;
  assign pos_mode  = (ctrl_q[SMP_CTRL_MODE_LSB +: 2] == SMP_MODE_POSITION) | full_mode;

  // Conditions that zero the command input range
  assign range_clear = deviation_clear  // [RL9]
                     | (ctrl_q[SMP_CTRL_OTSEQ_LSB +: 2] == SMP_OTSEQ_CLEAR
                        & overtravel_inhibit)  // [RL9]
                     | (comm_trial_run ^ comm_trial_q);  // [RL10]

  // Edge memory for the communication trial run
  always_ff @(posedge aclk) begin
    if (!aresetn) comm_trial_q <= 1'b0;
    else          comm_trial_q <= comm_trial_run;
  end

  // Command accumulation and its running extent
  smp_range_track #(
    .W (POS_W)
  ) u_track (
    .aclk       (aclk),
    .aresetn    (aresetn),         // [RL8]
    .clear      (range_clear),
    .step_valid (cmd_step_valid),  // [RL18]
    .step       (cmd_step),
    .acc_q      (acc_q),
    .min_q      (min_q),
    .max_q      (max_q)
  );

  // Origin of the range: motor position whenever the range is zeroed
  always_ff @(posedge aclk) begin
    if (!aresetn) base_q <= '0;
    else if (range_clear || !servo_on) base_q <= motor_pos;  // [RL6]
  end

  // Movable range: command extent widened by travel on both sides
  assign rel_pos = ext(motor_pos) - ext(base_q);
  assign lo_lim  = ext(min_q) - EW'(travel_q[POS_W-1:0]);  // [RL7]
  assign hi_lim  = ext(max_q) + EW'(travel_q[POS_W-1:0]);  // [RL7]

  // Working range only in position modes, servo on and no tool test running
  assign range_armed = pos_mode  // [RL2]
                     & servo_on  // [RL3]
                     & ~(tool_trial_run | tool_freq_measure)  // [RL5]
                     & ~range_clear;

  // Deviation source: raw encoder deviation bypasses filter and damping
  assign dev_mag = ctrl_q[SMP_CTRL_UNIT_BIT] ? mag(ext(enc_unit_deviation))  // [RL13] [RL15]
                                             : mag(ext(cmd_unit_deviation)); // [RL13]

  // Raw detections
  always_comb begin
    det               = '0;
    det[SMP_EV_RANGE] = range_armed & ((rel_pos < lo_lim) | (rel_pos > hi_lim));  // [RL1]
    det[SMP_EV_DEV]   = pos_mode & (dev_mag > EW'(dev_level_q[POS_W-1:0]));       // [RL12]
    det[SMP_EV_HYB]   = full_mode
                      & (mag(ext(motor_pos) - ext(scale_pos))
                         > EW'(hyb_level_q[POS_W-1:0]));                          // [RL16]
    det[SMP_EV_OVS]   = mag(ext(motor_speed)) > EW'(ovs_level_q[POS_W-1:0]);      // [RL11]
  end

  // New alarms only; a latched alarm does not re-raise its event
  assign evt = det & ~alarm_q;

  // Latched alarms, released only by the alarm-clear strobe
  always_ff @(posedge aclk) begin
    if (!aresetn)       alarm_q <= '0;
    else if (alarm_clr) alarm_q <= det;
    else                alarm_q <= alarm_q | det;
  end

  // Sticky status; a set in the read cycle survives the clear
  always_ff @(posedge aclk) begin
    if (!aresetn)       status_q <= '0;
    else if (status_rd) status_q <= evt;
    else                status_q <= status_q | evt;
  end

  // Interrupt level from unmasked status, one cycle behind the status bit
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_q <= 1'b0;
    else          irq_q <= |(status_q & mask_q);
  end

  // Controlled stop: decelerate by the chosen sequence, then hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_q          <= SMP_RUN;
      decel_stop_q    <= 1'b0;
      motor_halted_q  <= 1'b0;
      stop_sequence_q <= 2'h0;
    end else begin
      case (stop_q)
        SMP_RUN: begin
          if (|alarm_q) begin
            stop_q          <= SMP_DECEL;
            decel_stop_q    <= 1'b1;  // [RL4]
            stop_sequence_q <= ctrl_q[SMP_CTRL_STOP_LSB +: 2];  // [RL4]
          end
        end
        SMP_DECEL: begin
          if (motor_speed == '0) begin
            stop_q         <= SMP_HALT;
            decel_stop_q   <= 1'b0;
            motor_halted_q <= 1'b1;
          end
        end
        SMP_HALT: begin
          if (alarm_q == '0) begin
            stop_q         <= SMP_RUN;
            motor_halted_q <= 1'b0;
          end
        end
        default: stop_q <= SMP_RUN;
      endcase
    end
  end

  // Torque limit indication, registered for a clean output
  always_ff @(posedge aclk) begin
    if (!aresetn) torque_in_limit_output <= 1'b0;
    else          torque_in_limit_output <= torque_at_limit;  // [RL17]
  end

endmodule : smp_protect
`default_nettype wire

// [verification/smp_protect_asserts.sv]
// Port-level properties of the protection block.
// Assumes the bench keeps the reset value of the over-speed level.
`timescale 1ns/10ps
`default_nettype none
module smp_protect_asserts
  import smp_pkg::*;
#(
  parameter int POS_W = 32
) (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    s_axi_wvalid,
  input wire logic                    servo_on,
  input wire logic                    tool_trial_run,
  input wire logic                    deviation_clear,
  input wire logic                    torque_at_limit,
  input wire logic signed [POS_W-1:0] motor_speed,
  input wire logic                    torque_in_limit_output,
  input wire logic                    decel_stop_q,
  input wire logic [SMP_EV_N-1:0]     alarm_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Reset level, 5000 times 1.2; a rewritten level would void a_ovs_raise
  localparam int OVS = 6000;

  // Alarm onset, then the stop ramp one edge later
  sequence s_alarm_rise;
    $rose(|alarm_q);
  endsequence
  sequence s_decel_next;
    ##1 decel_stop_q;
  endsequence

  a_tlc_follow: assert property (torque_at_limit |=> torque_in_limit_output)
    else $error("torque limit flag missed");
  a_tlc_drop: assert property (!torque_at_limit |=> !torque_in_limit_output)
    else $error("torque limit flag stuck");
  a_decel_start: assert property (s_alarm_rise |-> s_decel_next)
    else $error("no deceleration after alarm");
  a_servo_gate: assert property (!servo_on |=> !$rose(alarm_q[SMP_EV_RANGE]))
    else $error("range alarm with servo off");
  a_tool_gate: assert property (tool_trial_run |=> !$rose(alarm_q[SMP_EV_RANGE]))
    else $error("range alarm during tool test");
  a_clear_gate: assert property (deviation_clear |=> !$rose(alarm_q[SMP_EV_RANGE]))
    else $error("range alarm while clearing");
  a_ovs_raise: assert property ((motor_speed > OVS || motor_speed < -OVS) |=>
    alarm_q[SMP_EV_OVS]) else $error("over-speed not raised");
  a_alarm_hold: assert property (alarm_q[SMP_EV_OVS] && !s_axi_wvalid &&
    !$past(s_axi_wvalid) |=> alarm_q[SMP_EV_OVS]) else $error("alarm dropped");
endmodule : smp_protect_asserts
bind smp_protect smp_protect_asserts #(.POS_W(POS_W)) u_smp_protect_asserts (.*);
`default_nettype wire

// [verification/smp_host_model.sv]
// Host controller model: servo-on level and position command steps.
// Assumes the bench asks for one step per request pulse.
`timescale 1ns/10ps
`default_nettype none
module smp_host_model (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          srv_req,
  input  wire logic          step_req,
  input  wire logic [31:0]   step_amt,
  output logic               servo_on = 1'b0,
  output logic               cmd_step_valid = 1'b0,
  output logic signed [31:0] cmd_step = 32'h0000_0000
);
  // Idle step data toggles so a stale value never passes for a command
  always @(posedge aclk) begin
    servo_on       <= aresetn && srv_req;
    cmd_step_valid <= aresetn && step_req;
    cmd_step       <= step_req ? step_amt : ~cmd_step;
  end
endmodule : smp_host_model
`default_nettype wire

// [verification/tb_servo_motion_protection.sv]
// Self-checking bench for the protection block with a host model.
// Assumes reset levels and the byte map of the shared package.
`timescale 1ns/10ps
`default_nettype none
module tb_servo_motion_protection
  import smp_pkg::*;
;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, alarm_q;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, stop_sequence_q;
  logic        srv_req = 0, step_req = 0, servo_on, cmd_step_valid, torque_at_limit = 0;
  logic signed [31:0] cmd_step, step_amt = 0, motor_pos = 0, scale_pos = 0, motor_speed = 0;
  logic signed [31:0] cmd_unit_deviation = 0, enc_unit_deviation = 0;
  logic        deviation_clear = 0, overtravel_inhibit = 0, tool_trial_run = 0;
  logic        tool_freq_measure = 0, comm_trial_run = 0;
  logic        torque_in_limit_output, decel_stop_q, motor_halted_q, irq_q;
  logic [33:0] exp_q[$];
  logic [15:0] rnd = 16'hF443;
  int          bad_count = 0, tests_run = 0, sum = 0;
  int tc[8] = '{0, 0, 2, 16, 16, 3, 3, 0};
  int td[8] = '{100000, 100001, 100001, 100001, 0, 0, 0, 0};
  int te[8] = '{0, 0, 0, 0, 100001, 0, 0, 0};
  int ts[8] = '{0, 0, 0, 0, 0, -16000, -16001, -16001};
  int tx[8] = '{0, 2, 0, 0, 2, 0, 4, 0};

  always #10 aclk = ~aclk;
  smp_protect u_smp_protect (.*);
  smp_host_model u_smp_host_model (.*);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  task automatic ca(input logic [3:0] e);
    repeat (4) @(posedge aclk);
    chk(34'(alarm_q), 34'(e));
  endtask : ca
  // Both write channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    aw_ok = 0;
    w_ok  = 0;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awready && !aw_ok) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_ok) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    exp_q.push_back(e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd

  // Oldest noted read result against what the bus returns
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
  end
  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SMP_OFS_TRAVEL, 34'h0_0000_2710);
    rd(SMP_OFS_DEV_LEVEL, 34'h0_0001_86A0);
    rd(SMP_OFS_HYB_LEVEL, 34'h0_0000_3E80);
    rd(SMP_OFS_OVS_LEVEL, 34'h0_0000_1770);
    rd(SMP_OFS_RANGE_MAX, 34'h0_0000_0000);
    rd(8'h28, {SMP_RESP_SLVERR, 32'h0000_0000});
    // Random speeds under the level; torque flag follows the drive
    repeat (8) begin
      rnd = lfsr(rnd);
      motor_speed     <= 32'(rnd[11:0]) + 1;
      torque_at_limit <= rnd[0];
      repeat (2) @(posedge aclk);
      chk(34'(torque_in_limit_output), 34'(rnd[0]));
    end
    // Far position is ignored in velocity mode, tool test and clearing
    motor_pos <= 20000;
    srv_req   <= 1'b1;
    wr(SMP_OFS_CTRL, 32'h0000_0001);
    motor_pos <= 40000;
    ca(4'h0);
    tool_trial_run <= 1'b1;
    wr(SMP_OFS_CTRL, 32'h0000_0000);
    ca(4'h0);
    tool_trial_run  <= 1'b0;
    deviation_clear <= 1'b1;
    ca(4'h0);
    overtravel_inhibit <= 1'b1;
    wr(SMP_OFS_CTRL, 32'h0000_004C);
    motor_pos          <= 60000;
    deviation_clear    <= 1'b0;
    ca(4'h0);
    overtravel_inhibit <= 1'b0;
    repeat (3) begin
      rnd = lfsr(rnd);
      step_amt <= 32'(rnd[7:0]);
      step_req <= 1'b1;
      sum += rnd[7:0];
      @(posedge aclk);
      step_req <= 1'b0;
      @(posedge aclk);
    end
    rd(SMP_OFS_RANGE_MAX, 34'(sum));
    rd(SMP_OFS_RANGE_MIN, 34'h0);
    motor_pos <= 70000 + sum;
    ca(4'h0);
    motor_pos <= 70001 + sum;
    ca(4'h1);
    chk(34'({decel_stop_q, motor_halted_q, stop_sequence_q}), 34'hB);
    chk(34'(irq_q), 34'h0);
    wr(SMP_OFS_MASK, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk(34'(irq_q), 34'h1);
    motor_pos <= 60000;
    rd(SMP_OFS_STATUS, 34'h1);
    rd(SMP_OFS_STATUS, 34'h0);
    chk(34'(irq_q), 34'h0);
    wr(SMP_OFS_CTRL, 32'h0000_0080);
    ca(4'h0);
    motor_pos <= 49999;
    ca(4'h1);
    motor_pos <= 60000;
    wr(SMP_OFS_CTRL, 32'h0000_0080);
    comm_trial_run <= 1'b1;
    rd(SMP_OFS_RANGE_MAX, 34'h0);
    comm_trial_run <= 1'b0;
    srv_req   <= 1'b0;
    motor_pos <= 0;
    ca(4'h0);
    srv_req     <= 1'b1;
    motor_speed <= 6000;
    ca(4'h0);
    motor_speed <= -6001;
    ca(4'h8);
    motor_speed <= 0;
    // Deviation unit, mode and hybrid cases, each from a cleared state
    for (int i = 0; i < 8; i++) begin
      cmd_unit_deviation <= 0;
      enc_unit_deviation <= 0;
      scale_pos          <= 0;
      wr(SMP_OFS_CTRL, 32'(tc[i] + 128));
      cmd_unit_deviation <= td[i];
      enc_unit_deviation <= te[i];
      scale_pos          <= ts[i];
      ca(4'(tx[i]));
    end
    summarize();
  end
endmodule : tb_servo_motion_protection
`default_nettype wire
